// file: rtl/sram_access_pkg.sv
// Constants, timing and carrier types for the static RAM host controller.
// Assumes a 10 MHz core clock; all pin timing is derived from it.
package sram_access_pkg;

    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 100;

    // Figures of the slowest grade, so any grade is served
    localparam int READ_CYCLE_NS  = 200;
    localparam int WRITE_CYCLE_NS = 200;
    localparam int WE_PULSE_NS    = 125;
    localparam int DATA_SETUP_NS  = 100;
    localparam int ACCESS_NS      = 200;
    localparam int BUS_FLOAT_NS   = 100;

    function automatic int ceil_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] READ_CYCLES =
        CNT_W'(ceil_cycles(ACCESS_NS > READ_CYCLE_NS ? ACCESS_NS : READ_CYCLE_NS));
    localparam logic [CNT_W-1:0] WE_CYCLES =
        CNT_W'(ceil_cycles(WE_PULSE_NS > DATA_SETUP_NS ? WE_PULSE_NS : DATA_SETUP_NS));
    localparam logic [CNT_W-1:0] WRITE_CYCLES = CNT_W'(ceil_cycles(WRITE_CYCLE_NS));
    localparam logic [CNT_W-1:0] FLOAT_CYCLES = CNT_W'(ceil_cycles(BUS_FLOAT_NS));
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } request_type;

    typedef struct packed {
        logic              sel_n;
        logic              sel;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
    } strobes_type;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_READ  = 5'h02,
        ST_FLOAT = 5'h04,
        ST_WRITE = 5'h08,
        ST_REST  = 5'h10
    } state_type;

    localparam strobes_type STROBES_IDLE = '{sel_n: 1'b1, sel: 1'b0, oe_n: 1'b1,
                                             we_n: 1'b1, addr: '0};
endpackage

// file: rtl/sram_host.sv
// Host controller driving a 128K x 8 asynchronous static RAM by its pins.
// Assumes requests come from logic on core_clk and the data pins from outside.
//
// Summary of operation
// - Select and write strobe fall on the same edge; write strobe releases first.
// - Write data held stable from before strobe rise through it.
// - Output enable stays high in writes, so no turn-off is paid.
// - Address driven no later than select activation.
// - Host drives data only while RAM outputs are off.
// - Reads spaced at least one read cycle apart.
// - Writes spaced at least one write cycle apart.
// - Write enable held low for at least the pulse width.
`timescale 1ns/10ps
`default_nettype none

module sram_host (
    input  wire logic                                core_clk,
    input  wire logic                                rst,
    input  wire sram_access_pkg::request_type        req,
    input  wire logic                                req_valid,
    output logic                                     req_ready,
    output logic [sram_access_pkg::DATA_W-1:0]       rdata,
    output logic                                     rdata_valid,
    output sram_access_pkg::strobes_type             pins,
    input  wire logic [sram_access_pkg::DATA_W-1:0]  dq_in,
    output logic [sram_access_pkg::DATA_W-1:0]       dq_out,
    output logic                                     dq_oe
);

    // ---------------------------------------------------------------
    // Data pin synchroniser
    // ---------------------------------------------------------------
    logic [sram_access_pkg::DATA_W-1:0] dq_meta;
    logic [sram_access_pkg::DATA_W-1:0] dq_sync;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dq_meta <= '0;
            dq_sync <= '0;
        end else begin
            dq_meta <= dq_in;
            dq_sync <= dq_meta;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    sram_access_pkg::state_type         state;
    logic [sram_access_pkg::CNT_W-1:0]  count;

    // ---------------------------------------------------------------
    // Phase counter helpers
    // ---------------------------------------------------------------
    // True in the last cycle of a timed phase
    function automatic logic count_done(input logic [sram_access_pkg::CNT_W-1:0] c);
        return c == sram_access_pkg::CNT_ONE;
    endfunction

    // Counts a timed phase down by one cycle
    function automatic logic [sram_access_pkg::CNT_W-1:0] count_step(
        input logic [sram_access_pkg::CNT_W-1:0] c
    );
        return c - sram_access_pkg::CNT_ONE;
    endfunction

    // A request is taken when valid meets ready at an edge
    logic take;

    always_comb begin
        take = req_valid && req_ready;
    end

    // Access may end exactly on an edge, so the bus is sampled one edge later;
    // two sync stages then carry that sample to the read register, and the
    // select window is stretched to cover both
    localparam logic [sram_access_pkg::CNT_W-1:0] SYNC_SLACK = 4'h3;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= sram_access_pkg::ST_IDLE;
            count <= sram_access_pkg::CNT_ZERO;
        end else begin
            case (state)
                sram_access_pkg::ST_IDLE: begin
                    if (take) begin
                        if (req.write) begin
                            state <= sram_access_pkg::ST_WRITE;
                            count <= sram_access_pkg::WE_CYCLES;
                        end else begin
                            state <= sram_access_pkg::ST_READ;
                            count <= sram_access_pkg::READ_CYCLES + SYNC_SLACK;
                        end
                    end
                end
                sram_access_pkg::ST_READ: begin
                    if (count_done(count)) begin
                        state <= sram_access_pkg::ST_FLOAT;
                        count <= sram_access_pkg::FLOAT_CYCLES;
                    end else begin
                        count <= count_step(count);
                    end
                end
                sram_access_pkg::ST_FLOAT: begin
                    if (count_done(count)) begin
                        state <= sram_access_pkg::ST_IDLE;
                    end else begin
                        count <= count_step(count);
                    end
                end
                sram_access_pkg::ST_WRITE: begin
                    if (count_done(count)) begin
                        state <= sram_access_pkg::ST_REST;
                        count <= sram_access_pkg::WRITE_CYCLES;
                    end else begin
                        count <= count_step(count);
                    end
                end
                sram_access_pkg::ST_REST: begin
                    if (count_done(count)) begin
                        state <= sram_access_pkg::ST_IDLE;
                    end else begin
                        count <= count_step(count);
                    end
                end
                default: begin
                    state <= sram_access_pkg::ST_IDLE;
                    count <= sram_access_pkg::CNT_ZERO;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Pin drive
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins   <= sram_access_pkg::STROBES_IDLE;
            dq_out <= '0;
            dq_oe  <= 1'b0;
        end else begin
            case (state)
                sram_access_pkg::ST_IDLE: begin
                    if (take) begin
                        pins.addr  <= req.addr;
                        pins.sel_n <= 1'b0;
                        pins.sel   <= 1'b1;
                        pins.oe_n  <= req.write;
                        pins.we_n  <= !req.write;
                        dq_out     <= req.wdata;
                        dq_oe      <= req.write;
                    end
                end
                sram_access_pkg::ST_READ: begin
                    if (count_done(count)) begin
                        pins.oe_n  <= 1'b1;
                        pins.sel_n <= 1'b1;
                        pins.sel   <= 1'b0;
                    end
                end
                sram_access_pkg::ST_WRITE: begin
                    if (count_done(count)) begin
                        pins.we_n <= 1'b1;
                    end
                end
                sram_access_pkg::ST_REST: begin
                    pins.sel_n <= 1'b1;
                    pins.sel   <= 1'b0;
                    dq_oe      <= 1'b0;
                end
                default: begin
                    dq_oe <= 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Request handshake and read return
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state == sram_access_pkg::ST_IDLE) && !take;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata       <= '0;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= 1'b0;
            // Taken at the select window's last edge, while the RAM still drives
            if (state == sram_access_pkg::ST_READ && count_done(count)) begin
                rdata       <= dq_sync;
                rdata_valid <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// file: dv/sram_model.sv
// Behavioural 128K x 8 static RAM on the host controller's pins.
// Assumes registered strobes; read data appears ACC_NS after a read opens.
`timescale 1ns/10ps
`default_nettype none
module sram_model #(
    parameter int ACC_NS = 200
) (
    input  wire sram_access_pkg::strobes_type pins,
    input  wire logic [7:0]                   dq_out,
    input  wire logic                         dq_oe,
    output logic [7:0]                        dq_in
);
    logic [7:0] mem [0:131071];
    logic [7:0] last = 8'h00;
    wire sel_on = !pins.sel_n && pins.sel;
    wire wr_on  = sel_on && !pins.we_n;
    wire rd_on  = sel_on && !pins.oe_n && pins.we_n;
    always @(negedge wr_on) mem[pins.addr] = dq_out;
    always @* if (rd_on) last = mem[pins.addr];
    // Released bus shows the inverse of the last byte, never a stale copy
    assign #(ACC_NS) dq_in = rd_on ? mem[pins.addr] : (dq_oe ? dq_out : ~last);
endmodule
`default_nettype wire

// file: dv/sram_host_sva.sv
// Port assertions for the static RAM host controller.
// Assumes one clock domain; bound to every sram_host instance.
`timescale 1ns/10ps
`default_nettype none
module sram_host_sva (
    input wire logic                         core_clk,
    input wire logic                         rst,
    input wire sram_access_pkg::request_type req,
    input wire logic                         req_valid,
    input wire logic                         req_ready,
    input wire logic [7:0]                   rdata,
    input wire logic                         rdata_valid,
    input wire sram_access_pkg::strobes_type pins,
    input wire logic [7:0]                   dq_in,
    input wire logic [7:0]                   dq_out,
    input wire logic                         dq_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_sel_agree: assert property (pins.sel_n == !pins.sel) else $error("selects split");
    a_bus_clash: assert property (dq_oe |-> pins.oe_n) else $error("bus clash");
    a_read_mode: assert property (!pins.oe_n |-> pins.we_n && !pins.sel_n) else $error("bad read");
    a_write_mode: assert property (!pins.we_n |-> !pins.sel_n && pins.oe_n && dq_oe)
        else $error("bad write");
    a_we_width: assert property ($fell(pins.we_n) |-> !pins.we_n [*2] ##1 pins.we_n)
        else $error("write pulse width");
    a_we_first: assert property ($rose(pins.we_n) |-> !pins.sel_n && dq_oe && $stable(dq_out)
        ##1 pins.sel_n) else $error("write end order");
    a_addr_hold: assert property (!pins.sel_n && !$past(pins.sel_n) |-> $stable(pins.addr))
        else $error("address moved");
    a_sel_span: assert property ($fell(pins.sel_n) |-> !pins.sel_n [*3])
        else $error("cycle too short");
    a_read_ans: assert property (req_valid && req_ready && !req.write |-> ##6 rdata_valid)
        else $error("read answer late");
    a_float_wait: assert property ($rose(pins.oe_n) |-> !dq_oe [*2]) else $error("no float");
endmodule
bind sram_host sram_host_sva chk (.core_clk(core_clk), .rst(rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
    .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the static RAM host controller.
// Assumes the RAM model on the pins and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                         core_clk = 1'b0;
    logic                         rst = 1'b1;
    logic                         req_valid = 1'b0;
    logic                         req_ready, rdata_valid, dq_oe;
    logic [7:0]                   rdata, dq_in, dq_out;
    logic [7:0]                   ref_mem [int];
    logic [31:0]                  seed = 32'h7f92;
    int                           num_errors = 0;
    int                           tests_run = 0;
    sram_access_pkg::request_type req = '0;
    sram_access_pkg::strobes_type pins;
    always #50 core_clk = ~core_clk;
    sram_host uut (.core_clk(core_clk), .rst(rst), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid), .pins(pins),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    sram_model ram (.pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [16:0] a, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        req <= '{write: w, addr: a, wdata: d};
        req_valid <= 1'b1;
        n = 0;
        @(posedge core_clk);
        while (req_ready !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        req_valid <= 1'b0;
        cmp(n < 20, 1'b1);
        if (w) ref_mem[a] = d;
        else begin
            n = 0;
            while (rdata_valid !== 1'b1 && n < 10) begin
                @(posedge core_clk);
                n++;
            end
            cmp(n < 10, 1'b1);
            cmp(rdata, ref_mem[a]);
        end
    endtask
    task automatic print_verdict();
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        print_verdict();
    end
    initial begin
        logic [16:0] a;
        repeat (20) @(posedge core_clk);
        cmp(pins, sram_access_pkg::STROBES_IDLE);
        cmp(dq_oe, 1'b0);
        rst <= 1'b0;
        xfer(1'b1, 17'h00000, 8'h3c);
        xfer(1'b1, 17'h1ffff, 8'hc3);
        xfer(1'b0, 17'h00000, 8'h00);
        xfer(1'b0, 17'h1ffff, 8'h00);
        $display("test boundary done errors=%0d", num_errors);
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            a = {seed[25] ? 13'h1fff : 13'h0000, seed[12:9]};
            if (seed[0] && ref_mem.exists(a)) xfer(1'b0, a, 8'h00);
            else xfer(1'b1, a, seed[8:1]);
        end
        $display("test random done errors=%0d", num_errors);
        @(posedge core_clk);
        req <= '{write: 1'b1, addr: 17'h00005, wdata: 8'h99};
        req_valid <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b1;
        req_valid <= 1'b0;
        @(posedge core_clk);
        cmp(pins, sram_access_pkg::STROBES_IDLE);
        cmp(dq_oe, 1'b0);
        ref_mem.delete(5);
        rst <= 1'b0;
        xfer(1'b0, 17'h1ffff, 8'h00);
        $display("test reset done errors=%0d", num_errors);
        print_verdict();
    end
endmodule
`default_nettype wire
